//--- ipm_map.svh
// register map, field positions, reset values, vectors and timing for the interrupt and power block
`ifndef IPM_MAP_SVH
`define IPM_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IPM_MISC_OFS 12'h020
`define IPM_EXTEN_OFS 12'h024
`define IPM_STATUS_OFS 12'h028
`define IPM_VECTOR_OFS 12'h02C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define IPM_MISC_SLOW 0
`define IPM_MISC_PRE_LO 1
`define IPM_MISC_PRE_HI 2
`define IPM_MISC_SENS_LO 3
`define IPM_MISC_SENS_HI 4
`define IPM_MISC_RST 5'h00
`define IPM_EXTEN_RST 10'h000
`define IPM_ST_MASK 16
`define IPM_ST_STATE 17
`define IPM_ST_EXT 21
`define IPM_ST_TRAP 22
`define IPM_ST_BOOT 23

// ----------------------------------------------------------------
// vector addresses (lower byte address of each pair)
// ----------------------------------------------------------------
`define IPM_VEC_RESET 16'hFFFE
`define IPM_VEC_SOFT 16'hFFFC
`define IPM_VEC_L0 16'hFFFA
`define IPM_VEC_L1 16'hFFF8
`define IPM_VEC_L2 16'hFFF6
`define IPM_VEC_L3 16'hFFF4
`define IPM_VEC_L4 16'hFFF2
`define IPM_VEC_L5 16'hFFF0
`define IPM_VEC_L6 16'hFFEE
`define IPM_VEC_L7 16'hFFEC
`define IPM_VEC_L8 16'hFFEA
`define IPM_VEC_L9 16'hFFE8
`define IPM_VEC_L10 16'hFFE6
`define IPM_VEC_L11 16'hFFE4
`define IPM_VEC_L12 16'hFFE2

// ----------------------------------------------------------------
// clock division and timing
// ----------------------------------------------------------------
`define IPM_DIV_NORMAL 6'h02
`define IPM_DIV_SLOW00 6'h04
`define IPM_DIV_SLOW10 6'h08
`define IPM_DIV_SLOW01 6'h10
`define IPM_DIV_SLOW11 6'h20
`define IPM_STARTUP_CYCLES 4096

`endif

//--- ipm_pkg.sv
// types shared by the interrupt and power block
package ipm_pkg;
   localparam int IPM_LEVELS = 13;
   typedef logic [IPM_LEVELS-1:0] ipm_pend_t;
   typedef enum logic [3:0]
   {
      ST_RUN = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_HALT = 4'b0100,
      ST_START = 4'b1000
   } ipm_state_t;
endpackage

//--- ipm_arb_if.sv
// carrier between the controller and its priority arbiter
interface ipm_arb_if;
   import ipm_pkg::*;
   ipm_pend_t pending;
   logic hit;
   logic [3:0] level;
   logic [15:0] vector;
   modport arb (input pending, output hit, level, vector);
   modport ctl (output pending, input hit, level, vector);
endinterface

//--- ipm_arbiter.sv
// fixed priority arbiter with registered vector lookup
`include "ipm_map.svh"
module ipm_arbiter
   import ipm_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // arbitration carrier
   ipm_arb_if.arb arb
);
   // ----------------------------------------------------------------
   // lookup functions
   // ----------------------------------------------------------------
   // lowest index wins: level 0 beats everything
   function automatic logic [3:0] first_set(input ipm_pend_t p);
      logic [3:0] r;
      r = 4'h0;
      for (int i = IPM_LEVELS - 1; i >= 0; i--)
      begin
         if (p[i])
            r = 4'(i);
      end
      return r;
   endfunction

   function automatic logic [15:0] vector_of(input logic [3:0] lv);
      logic [15:0] v;
      v = `IPM_VEC_L12;
      unique case (lv)
         4'h0: v = `IPM_VEC_L0;
         4'h1: v = `IPM_VEC_L1;
         4'h2: v = `IPM_VEC_L2;
         4'h3: v = `IPM_VEC_L3;
         4'h4: v = `IPM_VEC_L4;
         4'h5: v = `IPM_VEC_L5;
         4'h6: v = `IPM_VEC_L6;
         4'h7: v = `IPM_VEC_L7;
         4'h8: v = `IPM_VEC_L8;
         4'h9: v = `IPM_VEC_L9;
         4'hA: v = `IPM_VEC_L10;
         4'hB: v = `IPM_VEC_L11;
         4'hC: v = `IPM_VEC_L12;
         default: v = `IPM_VEC_L12;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // registered winner
   // ----------------------------------------------------------------
   // fixed priority pick
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         arb.hit <= 1'b0;
         arb.level <= 4'h0;
         arb.vector <= `IPM_VEC_L0;
      end
      else
      begin
         arb.hit <= |arb.pending;
         arb.level <= first_set(arb.pending);
         arb.vector <= vector_of(first_set(arb.pending));
      end
   end
endmodule

//--- ipm_clkdiv.sv
// oscillator divider giving cpu and CAN clock enables (peripherals share the cpu enable)
`include "ipm_map.svh"
module ipm_clkdiv
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // control
   input wire logic osc_on,
   input wire logic slow_sel,
   input wire logic [1:0] prescale,
   // enables
   output logic cpu_ce,
   output logic can_ce
);
   logic [5:0] cnt;
   logic [5:0] ratio;
   logic can_ph;

   // ratio from mode select and prescaler (prescale is hi,lo)
   always_comb
   begin
      ratio = `IPM_DIV_NORMAL;
      if (slow_sel)
      begin
         unique case (prescale)
            2'b00: ratio = `IPM_DIV_SLOW00;
            2'b10: ratio = `IPM_DIV_SLOW10;
            2'b01: ratio = `IPM_DIV_SLOW01;
            2'b11: ratio = `IPM_DIV_SLOW11;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         cnt <= 6'h00;
         cpu_ce <= 1'b0;
      end
      else if (!osc_on)
      begin
         cnt <= 6'h00;
         cpu_ce <= 1'b0;
      end
      else if (cnt >= ratio - 6'h01)
      begin
         cnt <= 6'h00;
         cpu_ce <= 1'b1;
      end
      else
      begin
         cnt <= cnt + 6'h01;
         cpu_ce <= 1'b0;
      end
   end

   // CAN keeps the normal rate whatever slow mode says
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         can_ph <= 1'b0;
         can_ce <= 1'b0;
      end
      else
      begin
         can_ph <= osc_on ? ~can_ph : 1'b0;
         can_ce <= osc_on & can_ph;
      end
   end
endmodule

//--- ipm_top.sv
// interrupt prioritisation, vectoring and power mode control with APB registers
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`include "ipm_map.svh"
// Notes on behaviour
// - level zero highest, level twelve lowest
// - fixed source to level assignment
// - only levels zero, one, reset leave halt
// - enabled pins of group ORed together
// - reset, software, external pin vectors
// - CAN and bridge flags share vectors
// - timer one compare, capture, overflow vectors
// - timer two compare, capture, overflow vectors
// - converter and nvm vectors
// - pwm overflow vectors, no flag registers
// - slow mode divides by 4 to 32
// - instructions enter wait/halt, bits select slow
// - wait stops cpu clock, clears mask
// - wait exit branches straight to service
// - halt stops oscillator, clears mask
// - halt wake waits startup then services
// - halt with watchdog/safeguard forces reset
// - slow select zero means divide by two
// - prescaler codes select 4, 8, 16, 32
module ipm_top
   import ipm_pkg::*;
#(
   parameter int STARTUP_CYCLES = `IPM_STARTUP_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external pins
   input wire logic [7:0] port_a_pins,
   input wire logic [1:0] port_b_low_pins,
   // peripheral flags (levels, held by their owners)
   input wire logic can_receive_flag,
   input wire logic can_transmit_flag,
   input wire logic can_error_pending_flag,
   input wire logic bridge_short_flag,
   input wire logic overtemperature_flag,
   input wire logic [1:0] t1_compare_flag,
   input wire logic [1:0] t1_capture_flag,
   input wire logic t1_overflow_flag,
   input wire logic [1:0] t2_compare_flag,
   input wire logic [1:0] t2_capture_flag,
   input wire logic t2_overflow_flag,
   input wire logic adc_done_flag,
   input wire logic nvm_program_irq_enable,
   // pwm overflow pulses (no flag register of their own)
   input wire logic pwm1_overflow,
   input wire logic pwm2_overflow,
   // safety state
   input wire logic watchdog_enabled,
   input wire logic safeguard_enabled,
   // cpu core side
   input wire logic wait_for_interrupt_instruction,
   input wire logic halt_instruction,
   input wire logic software_interrupt,
   input wire logic mask_set,
   input wire logic mask_clear,
   input wire logic vector_ack,
   output logic irq_req,
   output logic [15:0] irq_vector,
   output logic interrupt_mask,
   output logic full_reset_req,
   // clock enables
   output logic osc_on,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic can_clk_en
);
   localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

   ipm_state_t state;
   logic [4:0] misc;
   logic [9:0] ext_en;
   logic [9:0] pins_prev;
   logic ext_pend;
   logic [1:0] pwm_pend;
   logic trap_pend;
   logic boot_pend;
   logic [CNT_W-1:0] start_cnt;
   logic cpu_ce;
   logic can_ce;
   logic [9:0] pins;
   logic [9:0] fall;
   logic [9:0] rise;
   logic ext_event;
   logic sens_change;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rd_mux;
   logic take;
   logic take_hw;
   ipm_pend_t raw_pend;

   ipm_arb_if arb_bus ();

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & ~penable & ~pwrite;
   assign addr_ok = (paddr == `IPM_MISC_OFS) | (paddr == `IPM_EXTEN_OFS) |
                    (paddr == `IPM_STATUS_OFS) | (paddr == `IPM_VECTOR_OFS);
   assign pslverr = psel & penable & ~addr_ok;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `IPM_MISC_OFS: rd_mux[4:0] = misc;
         `IPM_EXTEN_OFS: rd_mux[9:0] = ext_en;
         `IPM_STATUS_OFS:
         begin
            rd_mux[IPM_LEVELS-1:0] = raw_pend;
            rd_mux[`IPM_ST_MASK] = interrupt_mask;
            rd_mux[`IPM_ST_STATE +: 4] = state;
            rd_mux[`IPM_ST_EXT] = ext_pend;
            rd_mux[`IPM_ST_TRAP] = trap_pend;
            rd_mux[`IPM_ST_BOOT] = boot_pend;
         end
         `IPM_VECTOR_OFS: rd_mux[15:0] = irq_vector;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle so it is a flop in the access cycle
   always_ff @(posedge clk)
   begin
      if (srst)
         prdata <= 32'h0000_0000;
      else if (rd_en)
         prdata <= rd_mux;
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // sensitivity bits only move while the mask is set; a change drops the pin latch
   assign sens_change = wr_en & (paddr == `IPM_MISC_OFS) & interrupt_mask &
                        (pwdata[`IPM_MISC_SENS_HI:`IPM_MISC_SENS_LO] !=
                         misc[`IPM_MISC_SENS_HI:`IPM_MISC_SENS_LO]);

   always_ff @(posedge clk)
   begin
      if (srst)
         misc <= `IPM_MISC_RST;
      else if (wr_en && paddr == `IPM_MISC_OFS)
      begin
         misc[`IPM_MISC_PRE_HI:`IPM_MISC_SLOW] <= pwdata[`IPM_MISC_PRE_HI:`IPM_MISC_SLOW];
         if (interrupt_mask)
            misc[`IPM_MISC_SENS_HI:`IPM_MISC_SENS_LO] <= pwdata[`IPM_MISC_SENS_HI:`IPM_MISC_SENS_LO];
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         ext_en <= `IPM_EXTEN_RST;
      else if (wr_en && paddr == `IPM_EXTEN_OFS)
         ext_en <= pwdata[9:0];
   end

   // ----------------------------------------------------------------
   // external pin interrupt
   // ----------------------------------------------------------------
   assign pins = {port_b_low_pins, port_a_pins};
   assign fall = pins_prev & ~pins;
   assign rise = ~pins_prev & pins;

   // pins reset to high so a pin that is low after reset reads as a falling edge
   always_ff @(posedge clk)
   begin
      if (srst)
         pins_prev <= 10'h3FF;
      else
         pins_prev <= pins;
   end

   always_comb
   begin
      unique case (misc[`IPM_MISC_SENS_HI:`IPM_MISC_SENS_LO])
         2'b00: ext_event = |(ext_en & (fall | ~pins));
         2'b10: ext_event = |(ext_en & fall);
         2'b01: ext_event = |(ext_en & rise);
         2'b11: ext_event = |(ext_en & (fall | rise));
      endcase
   end

   // cleared on vector fetch or a sensitivity change; a new event wins over both
   always_ff @(posedge clk)
   begin
      if (srst)
         ext_pend <= 1'b0;
      else if (ext_event)
         ext_pend <= 1'b1;
      else if (sens_change || (take_hw && arb_bus.level == 4'h0))
         ext_pend <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         pwm_pend <= 2'b00;
      else
      begin
         pwm_pend[0] <= pwm1_overflow | (pwm_pend[0] & ~(take_hw && arb_bus.level == 4'hA));
         pwm_pend[1] <= pwm2_overflow | (pwm_pend[1] & ~(take_hw && arb_bus.level == 4'hB));
      end
   end

   // ----------------------------------------------------------------
   // level map and arbitration
   // ----------------------------------------------------------------
   // source to level map
   assign raw_pend = {nvm_program_irq_enable, pwm_pend[1], pwm_pend[0], adc_done_flag,
                      t2_overflow_flag, |t2_capture_flag, |t2_compare_flag,
                      t1_overflow_flag, |t1_capture_flag, |t1_compare_flag,
                      bridge_short_flag | overtemperature_flag,
                      can_receive_flag | can_transmit_flag | can_error_pending_flag,
                      ext_pend};
   // flags stay raised at the source until the cpu services them
   assign arb_bus.pending = raw_pend;

   ipm_arbiter u_arb
   (
      .clk (clk),
      .srst (srst),
      .arb (arb_bus)
   );

   // ----------------------------------------------------------------
   // cpu request and vector
   // ----------------------------------------------------------------
   // a flag that dropped since the arbiter sampled it is not offered
   assign take = vector_ack & irq_req;
   assign take_hw = take & ~boot_pend & ~trap_pend;

   always_comb
   begin
      irq_req = 1'b0;
      irq_vector = arb_bus.vector;
      if (state == ST_RUN)
      begin
         if (boot_pend)
         begin
            irq_req = 1'b1;
            irq_vector = `IPM_VEC_RESET;
         end
         else if (trap_pend)
         begin
            irq_req = 1'b1;
            irq_vector = `IPM_VEC_SOFT;
         end
         else
            irq_req = arb_bus.hit & ~interrupt_mask & raw_pend[arb_bus.level];
      end
   end

   // reset fetch request lives until the cpu takes the reset vector
   always_ff @(posedge clk)
   begin
      if (srst)
         boot_pend <= 1'b1;
      else if (take)
         boot_pend <= 1'b0;
   end

   // software trap ignores the mask
   always_ff @(posedge clk)
   begin
      if (srst)
         trap_pend <= 1'b0;
      else if (software_interrupt)
         trap_pend <= 1'b1;
      else if (take && !boot_pend)
         trap_pend <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         interrupt_mask <= 1'b1;
      else if (take || mask_set)
         interrupt_mask <= 1'b1;
      else if (state == ST_RUN && wait_for_interrupt_instruction)
         interrupt_mask <= 1'b0;
      else if (state == ST_RUN && halt_instruction && !watchdog_enabled && !safeguard_enabled)
         interrupt_mask <= 1'b0;
      else if (mask_clear)
         interrupt_mask <= 1'b0;
   end

   // ----------------------------------------------------------------
   // power mode sequencer
   // ----------------------------------------------------------------
   // reset also walks through the startup delay before the reset fetch
   always_ff @(posedge clk)
   begin
      if (srst)
         state <= ST_START;
      else
      begin
         unique case (state)
            ST_RUN:
            begin
               if (wait_for_interrupt_instruction)
                  state <= ST_WAIT;
               else if (halt_instruction && !watchdog_enabled && !safeguard_enabled)
                  state <= ST_HALT;
            end
            ST_WAIT:
            begin
               if (|raw_pend)
                  state <= ST_RUN;
            end
            ST_HALT:
            begin
               if (raw_pend[0] || raw_pend[1])
                  state <= ST_START;
            end
            ST_START:
            begin
               if (cpu_ce && start_cnt == CNT_W'(STARTUP_CYCLES - 1))
                  state <= ST_RUN;
            end
         endcase
      end
   end

   // counts cpu clock cycles of the restarted oscillator
   always_ff @(posedge clk)
   begin
      if (srst || state != ST_START)
         start_cnt <= '0;
      else if (cpu_ce)
         start_cnt <= start_cnt + CNT_W'(1);
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         full_reset_req <= 1'b0;
      else
         full_reset_req <= (state == ST_RUN) & halt_instruction & ~wait_for_interrupt_instruction &
                           (watchdog_enabled | safeguard_enabled);
   end

   // ----------------------------------------------------------------
   // clock enables
   // ----------------------------------------------------------------
   ipm_clkdiv u_div
   (
      .clk (clk),
      .srst (srst),
      .osc_on (osc_on),
      .slow_sel (misc[`IPM_MISC_SLOW]),
      .prescale ({misc[`IPM_MISC_PRE_HI], misc[`IPM_MISC_PRE_LO]}),
      .cpu_ce (cpu_ce),
      .can_ce (can_ce)
   );

   assign osc_on = (state != ST_HALT);
   assign cpu_clk_en = cpu_ce & (state == ST_RUN);
   // peripherals keep running in wait and during the startup delay
   assign periph_clk_en = cpu_ce & (state != ST_HALT);
   assign can_clk_en = can_ce & osc_on;
endmodule

//--- ipm_cpu_model.sv
// cpu core stand-in that takes vectors, promptly or after a stall
module ipm_cpu_model
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // stall select and request
   input wire logic slow,
   input wire logic irq_req,
   input wire logic [15:0] irq_vector,
   // answer and record
   output logic vector_ack,
   output logic [15:0] last_vec,
   output int taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] stall;
   // ack stands until an edge sees it with the request; a withdrawn request cancels it
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         vector_ack <= 1'b0;
         stall <= 2'd0;
         taken <= 0;
         last_vec <= 16'h0000;
      end
      else if (vector_ack && irq_req)
      begin
         vector_ack <= 1'b0;
         stall <= 2'd0;
         taken <= taken + 1;
         last_vec <= irq_vector;
      end
      else if (!irq_req)
      begin
         vector_ack <= 1'b0;
         stall <= 2'd0;
      end
      else if (!slow || stall == 2'd3)
         vector_ack <= 1'b1;
      else
         stall <= stall + 2'd1;
   end
endmodule

//--- ipm_top_chk.sv
// concurrent checks on the interrupt and power block ports
module ipm_top_chk
#(
   parameter int STARTUP_CYCLES = 4096
)
(
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // wake sources
   input wire logic [7:0] port_a_pins,
   input wire logic [1:0] port_b_low_pins,
   input wire logic can_receive_flag,
   input wire logic can_transmit_flag,
   input wire logic can_error_pending_flag,
   // guards and cpu side
   input wire logic watchdog_enabled,
   input wire logic safeguard_enabled,
   input wire logic wait_for_interrupt_instruction,
   input wire logic halt_instruction,
   input wire logic vector_ack,
   input wire logic irq_req,
   input wire logic interrupt_mask,
   input wire logic full_reset_req,
   // clock enables
   input wire logic osc_on,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic can_clk_en
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // no wake source: pins idle high, CAN silent; six cycles cover the pin synchroniser
   wire quiet = &{port_a_pins, port_b_low_pins} && !(can_receive_flag || can_transmit_flag || can_error_pending_flag);
   sequence s_halt_go;
      halt_instruction && !watchdog_enabled && !safeguard_enabled;
   endsequence
   sequence s_halt_idle;
      (!osc_on && quiet) [*6];
   endsequence
   chk_ack_mask: assert property (vector_ack && irq_req |=> interrupt_mask && !irq_req)
      else $error("accepted interrupt left mask clear");
   chk_wait_entry: assert property (wait_for_interrupt_instruction |=> !interrupt_mask && !cpu_clk_en)
      else $error("wait entry kept cpu clock or mask");
   chk_halt_entry: assert property (s_halt_go |=> !osc_on && !interrupt_mask)
      else $error("halt entry kept oscillator or mask");
   chk_halt_guard: assert property (halt_instruction && (watchdog_enabled || safeguard_enabled) |=> full_reset_req && osc_on)
      else $error("guarded halt gave no reset");
   chk_osc_gating: assert property (!osc_on |-> !cpu_clk_en && !periph_clk_en && !can_clk_en)
      else $error("clock enable while oscillator off");
   chk_halt_stays: assert property (s_halt_idle |=> !osc_on)
      else $error("halt left without a wake source");
   chk_startup_quiet: assert property ($rose(osc_on) |-> !irq_req [*8])
      else $error("request during oscillator startup");
   chk_can_rate: assert property (can_clk_en && osc_on |=> !can_clk_en ##1 (can_clk_en || !osc_on))
      else $error("CAN enable left divide by two");
endmodule
bind ipm_top ipm_top_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_chk (.*);

//--- ipm_top_tb.sv
// self-checking bench for the interrupt and power block
`include "ipm_map.svh"
module ipm_top_tb
   import ipm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, slow = 0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [7:0] port_a_pins = 8'hFF;
   logic [1:0] port_b_low_pins = 2'b11, pwm = 2'b00, gd = 2'b00;
   logic [3:0] cp = 4'h0;
   logic [16:0] fl = 17'h0_0000;
   logic irq_req, interrupt_mask, full_reset_req, osc_on, cpu_clk_en, periph_clk_en, can_clk_en, vector_ack;
   logic [15:0] irq_vector, last_vec;
   int taken, got, n, m, mismatches, check_count;
   logic [15:0] vecs [14] = '{`IPM_VEC_SOFT, `IPM_VEC_L0, `IPM_VEC_L1, `IPM_VEC_L2, `IPM_VEC_L3, `IPM_VEC_L4,
      `IPM_VEC_L5, `IPM_VEC_L6, `IPM_VEC_L7, `IPM_VEC_L8, `IPM_VEC_L9, `IPM_VEC_L10, `IPM_VEC_L11, `IPM_VEC_L12};
   logic [16:0] clr [14] = '{17'h0_0000, 17'h0_0000, 17'h0_0007, 17'h0_0018, 17'h0_0060, 17'h0_0180, 17'h0_0200,
      17'h0_0C00, 17'h0_3000, 17'h0_4000, 17'h0_8000, 17'h0_0000, 17'h0_0000, 17'h1_0000};
   logic [31:0] miscs [5] = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0003, 32'h0000_0007, 32'h0000_0000};
   int divs [5] = '{4, 8, 16, 32, 2};
   // ----------------------------------------------------------------
   // clock, design and cpu stand-in
   // ----------------------------------------------------------------
   always #4 clk = ~clk;
   // startup shortened to 8 cpu enables so halt wake stays brief
   ipm_top #(.STARTUP_CYCLES(8)) i_dut (.*, .can_receive_flag(fl[0]), .can_transmit_flag(fl[1]),
      .can_error_pending_flag(fl[2]), .bridge_short_flag(fl[3]), .overtemperature_flag(fl[4]),
      .t1_compare_flag(fl[6:5]), .t1_capture_flag(fl[8:7]), .t1_overflow_flag(fl[9]), .t2_compare_flag(fl[11:10]),
      .t2_capture_flag(fl[13:12]), .t2_overflow_flag(fl[14]), .adc_done_flag(fl[15]),
      .nvm_program_irq_enable(fl[16]), .pwm1_overflow(pwm[0]), .pwm2_overflow(pwm[1]),
      .watchdog_enabled(gd[0]), .safeguard_enabled(gd[1]), .wait_for_interrupt_instruction(cp[0]),
      .halt_instruction(cp[1]), .software_interrupt(cp[2]), .mask_clear(cp[3]), .mask_set(1'b0));
   ipm_cpu_model i_cpu (.*);
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // apb transfer: request held until the edge that sees pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // one-cycle cpu pulse: 0 wait, 1 halt, 2 software trap, 3 mask clear
   task automatic pulse(input int b);
      @(posedge clk);
      cp[b] <= 1'b1;
      @(posedge clk);
      cp <= 4'h0;
   endtask
   task automatic take(input logic [15:0] v);
      while (taken == got) @(posedge clk);
      got = taken;
      check("vector", last_vec, v);
   endtask
   task automatic gap;
      @(posedge clk);
      while (cpu_clk_en !== 1'b1) @(posedge clk);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (cpu_clk_en !== 1'b1);
   endtask
   // ----------------------------------------------------------------
   // watchdog and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      #100us;
      mismatches++;
      complete_run();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      take(`IPM_VEC_RESET);
      check("mask", interrupt_mask, 1);
      apb(0, `IPM_MISC_OFS, 0);
      check("misc", rd, `IPM_MISC_RST);
      apb(0, 12'h030, 0);
      check("unmapped err", err, 1);
      check("unmapped data", rd, 0);
      // cpu enable gap for each slow prescaler code, then normal mode
      for (int j = 0; j < 5; j++)
      begin
         apb(1, `IPM_MISC_OFS, miscs[j]);
         gap();
         gap();
         check("cpu gap", n, divs[j]);
      end
      // falling-edge sensitivity, pins 0 and 9 enabled, written while masked
      apb(1, `IPM_MISC_OFS, 32'h0000_0010);
      apb(1, `IPM_EXTEN_OFS, 32'h0000_0201);
      fl <= 17'h1_FFFF;
      pwm <= 2'b11;
      port_b_low_pins <= 2'b01;
      @(posedge clk);
      pwm <= 2'b00;
      repeat (4) @(posedge clk);
      check("masked", irq_req, 0);
      pulse(2);
      for (int k = 0; k < 14; k++)
      begin
         slow <= k[0];
         take(vecs[k]);
         fl <= fl & ~clr[k];
         port_b_low_pins <= 2'b11;
         repeat (2) @(posedge clk);
         if (k < 13)
            pulse(3);
      end
      pulse(0);
      n = 0;
      m = 0;
      repeat (20)
      begin
         @(posedge clk);
         n += cpu_clk_en;
         m += periph_clk_en;
      end
      check("wait cpu", n, 0);
      check("wait periph", m > 0, 1);
      check("wait mask", interrupt_mask, 0);
      fl <= 17'h0_8000;
      take(`IPM_VEC_L9);
      fl <= 17'h0_0000;
      repeat (2) @(posedge clk);
      for (int g = 1; g < 3; g++)
      begin
         gd <= g[1:0];
         pulse(1);
         @(posedge clk);
         check("guard", {full_reset_req, osc_on}, 2'b11);
      end
      gd <= 2'b00;
      pulse(1);
      @(posedge clk);
      check("halt", {osc_on, interrupt_mask}, 2'b00);
      fl <= 17'h1_8008;
      repeat (20) @(posedge clk);
      check("halt held", osc_on, 0);
      fl <= 17'h0_0002;
      while (osc_on !== 1'b1) @(posedge clk);
      n = 0;
      while (taken == got)
      begin
         @(posedge clk);
         n++;
      end
      check("startup", n >= 14 && n < 40, 1);
      take(`IPM_VEC_L1);
      fl <= 17'h0_0000;
      apb(1, `IPM_MISC_OFS, 32'h0000_0008);
      pulse(3);
      port_a_pins <= 8'hFE;
      repeat (3) @(posedge clk);
      check("rise only", irq_req, 0);
      port_a_pins <= 8'hFF;
      take(`IPM_VEC_L0);
      complete_run();
   end
endmodule
